// ===== pdc_pkg.sv
// Constants and types of the pin-controlled sleep block
package pdc_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_NS      = 100;  // Clock period in ns
  localparam int SETUP_NS    = 10;   // Inputs stable before sleep rises
  localparam int RECOVER_NS  = 2000; // Longest wake time after sleep falls
  // Least time rounds up, never below one cycle
  localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
                               (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // Longest time rounds down
  localparam int RECOVER_CYC = RECOVER_NS / CLK_NS;
  localparam int SYNC_LAT    = 4;    // Pin edge to filtered level, cycles
  // Wake cycles left after sync and state entry
  localparam int WAKE_CYC    = RECOVER_CYC - SYNC_LAT - 1;
  localparam int CNT_W       = 5;    // Wake counter width

  // ---------------------------------------------------------------
  // Pin layout and reset values
  // ---------------------------------------------------------------
  localparam int PIN_W       = 8;    // Default number of user pins
  localparam int SLEEP_BIT   = 0;    // Pin that doubles as sleep control
  localparam logic RST_OE    = 1'h0; // Outputs start undriven

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PDC_RUN,                         // Normal operation
    PDC_SLEEP,                       // Frozen, inputs blocked
    PDC_WAKE                         // Recovery before resuming
  } pdc_state_t;
endpackage

// ===== pdc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and hold latch
`timescale 1ns/1ns
module pdc_pin_sync #(
  parameter int W = pdc_pkg::PIN_W   // Number of pins
) (
  input  wire logic         clk,     // System clock
  input  wire logic         rst_n,   // Async reset, active low
  input  wire logic [W-1:0] pinIn,   // Raw pin levels
  input  wire logic [W-1:0] holdMsk, // High bits freeze their latch
  output logic      [W-1:0] pinQ     // Filtered, latched levels
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;                // First stage, read by s2 only
    logic [W-1:0] s2;                // Second stage
    logic [W-1:0] s3;                // Third stage
    logic [W-1:0] q;                 // Hold latch
  } pdc_sync_t;

  pdc_sync_t st_r;                   // Registered state
  pdc_sync_t st_nxt;                 // Next state

  // Shift pins in; latch only where stages agree and not held
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      // Held latch keeps the pin at a defined level
      if (!holdMsk[i] && st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // Register the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pinQ = st_r.q;
endmodule

// ===== pdc_power_down.sv
// Pin-controlled sleep sequencer that freezes pins and core state
//
// Overview of operation
// - Sleep pin high enters sleep when enabled
// - Outputs and core state held during sleep
// - Undriven outputs stay undriven through sleep
// - All inputs except sleep pin blocked
// - Pin hold latches keep levels while asleep
// - Static enable; otherwise pin is ordinary
// - Sleep pin's array input unavailable when enabled
// - Valid again within 2 us after fall
`timescale 1ns/1ns
module pdc_power_down #(
  parameter int W = pdc_pkg::PIN_W   // Number of user pins
) (
  input  wire logic         clk,         // 10 MHz system clock
  input  wire logic         rst_n,       // Async reset, active low
  input  wire logic         sleepEnable, // Static design option
  input  wire logic [W-1:0] pinIn,       // Raw input pins
  input  wire logic [W-1:0] coreData,    // Core output values
  input  wire logic [W-1:0] coreOe,      // Core output enables
  output logic      [W-1:0] toCore,      // Inputs seen by core
  output logic      [W-1:0] padOut,      // Output pin values
  output logic      [W-1:0] padOe,       // Output pin enables
  output logic              coreClkEn,   // Core register enable
  output logic              asleep       // Block is not running
);
  // ---------------------------------------------------------------
  // Local constants
  // ---------------------------------------------------------------
  localparam int WAKE_MAX = pdc_pkg::WAKE_CYC;     // Wake length, for counter load and assertions
  localparam int REC_MAX  = pdc_pkg::RECOVER_CYC;  // For assertions
  localparam logic [W-1:0] SLP_MSK = W'(1) << pdc_pkg::SLEEP_BIT;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    pdc_pkg::pdc_state_t          fsm;  // Sequencer state
    logic [pdc_pkg::CNT_W-1:0]    cnt;  // Wake countdown
    logic [W-1:0]                 in;   // Inputs passed to core
    logic [W-1:0]                 out;  // Held output values
    logic [W-1:0]                 oe;   // Held output enables
    logic                         ckEn; // Core clock enable
    logic                         slp;  // Not running flag
  } pdc_ctl_t;

  pdc_ctl_t     st_r;                // Registered state
  pdc_ctl_t     st_nxt;              // Next state
  logic [W-1:0] pinQ;                // Filtered pin levels
  logic [W-1:0] holdMsk;             // Latch freeze mask
  logic         sleepSeen;           // Sleep request, filtered

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  // Latches freeze while not running, except the sleep pin
  assign holdMsk = (st_r.fsm != pdc_pkg::PDC_RUN) ?
                   ~SLP_MSK : '0;

  pdc_pin_sync #(.W(W)) uSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   (pinIn),
    .holdMsk (holdMsk),
    .pinQ    (pinQ)
  );

  // Sleep only acts when the static option selects it
  assign sleepSeen = sleepEnable &
                     pinQ[pdc_pkg::SLEEP_BIT];

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r.fsm)
      pdc_pkg::PDC_RUN: begin
        if (sleepSeen) begin
          // Freeze everything as it stands
          st_nxt.fsm  = pdc_pkg::PDC_SLEEP;
          st_nxt.ckEn = 1'h0;
          st_nxt.slp  = 1'h1;
        end else begin
          // Pass inputs; mask array input of sleep pin when enabled
          st_nxt.in   = sleepEnable ? (pinQ & ~SLP_MSK) : pinQ;
          st_nxt.out  = coreData;
          st_nxt.oe   = coreOe;
          st_nxt.ckEn = 1'h1;
        end
      end
      pdc_pkg::PDC_SLEEP: begin
        // Outputs, enables and inputs all hold
        if (!sleepSeen) begin
          st_nxt.fsm = pdc_pkg::PDC_WAKE;
          st_nxt.cnt = pdc_pkg::CNT_W'(WAKE_MAX - 1);
        end
      end
      pdc_pkg::PDC_WAKE: begin
        if (sleepSeen) begin
          // Sleep again before recovery ends
          st_nxt.fsm = pdc_pkg::PDC_SLEEP;
        end else if (st_r.cnt == '0) begin
          // Resume from held state, no reset
          st_nxt.fsm  = pdc_pkg::PDC_RUN;
          st_nxt.ckEn = 1'h1;
          st_nxt.slp  = 1'h0;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'h1;
        end
      end
      default: begin
        st_nxt.fsm = pdc_pkg::PDC_RUN;
      end
    endcase
  end

  // Register the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.fsm  <= pdc_pkg::PDC_RUN;
      st_r.cnt  <= '0;
      st_r.in   <= '0;
      st_r.out  <= '0;
      st_r.oe   <= {W{pdc_pkg::RST_OE}};
      st_r.ckEn <= 1'h0;
      st_r.slp  <= 1'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign toCore    = st_r.in;
  assign padOut    = st_r.out;
  assign padOe     = st_r.oe;
  assign coreClkEn = st_r.ckEn;
  assign asleep    = st_r.slp;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [pdc_pkg::CNT_W:0] wakeAge;  // Cycles spent in wake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeAge <= '0;
    end else if (st_r.fsm == pdc_pkg::PDC_WAKE) begin
      wakeAge <= wakeAge + 1'h1;
    end else begin
      wakeAge <= '0;
    end
  end

  wire running = (st_r.fsm == pdc_pkg::PDC_RUN);

  sequence s_wakeLast;
    st_r.fsm == pdc_pkg::PDC_WAKE && st_r.cnt == '0 && !sleepSeen;
  endsequence
  sequence s_resumed;
    running && coreClkEn && !asleep;
  endsequence

  property p_enter;
    @(posedge clk) disable iff (!rst_n)
    running && sleepSeen |=> !running && asleep && !coreClkEn;
  endproperty
  a_enter: assert property (p_enter)
    else $error("Sleep request not taken");

  property p_holdOut;
    @(posedge clk) disable iff (!rst_n)
    !running |=> $stable(padOut);
  endproperty
  a_holdOut: assert property (p_holdOut)
    else $error("Output changed while asleep");

  property p_hizKeep;
    @(posedge clk) disable iff (!rst_n)
    !running |=> (padOe & ~$past(padOe)) == '0;
  endproperty
  a_hizKeep: assert property (p_hizKeep)
    else $error("Undriven output became driven while asleep");

  property p_inBlock;
    @(posedge clk) disable iff (!rst_n)
    !running |=> $stable(toCore);
  endproperty
  a_inBlock: assert property (p_inBlock)
    else $error("Input reached core while asleep");

  property p_keeper;
    @(posedge clk) disable iff (!rst_n)
    !running ##1 !running |-> $stable(pinQ & ~SLP_MSK);
  endproperty
  a_keeper: assert property (p_keeper)
    else $error("Hold latch moved while asleep");

  property p_ordinary;
    @(posedge clk) disable iff (!rst_n)
    !sleepEnable && running |=> running;
  endproperty
  a_ordinary: assert property (p_ordinary)
    else $error("Sleep entered with option off");

  property p_noArrayIn;
    @(posedge clk) disable iff (!rst_n)
    sleepEnable && running |=> !toCore[pdc_pkg::SLEEP_BIT];
  endproperty
  a_noArrayIn: assert property (p_noArrayIn)
    else $error("Sleep pin reached the core");

  property p_wakeBound;
    @(posedge clk) disable iff (!rst_n)
    $fell(sleepSeen) |-> ##[0:REC_MAX] (running || sleepSeen);
  endproperty
  a_wakeBound: assert property (p_wakeBound)
    else $error("Recovery took too long");

  property p_wakeLen;
    @(posedge clk) disable iff (!rst_n)
    wakeAge <= WAKE_MAX;
  endproperty
  a_wakeLen: assert property (p_wakeLen)
    else $error("Wake state overran");

  property p_resume;
    @(posedge clk) disable iff (!rst_n)
    s_wakeLast |=> s_resumed and $stable(padOut) and $stable(toCore);
  endproperty
  a_resume: assert property (p_resume)
    else $error("Resume did not keep held state");
endmodule

// ===== pdc_sleep_drv.sv
// Far-side model that drives the sleep control pin
`timescale 1ns/1ns
module pdc_sleep_drv (
  input  wire logic clk,       // System clock
  input  wire logic sleepReq,  // Bench asks for sleep
  output logic      sleepLine, // Sleep control pin level
  output logic      recovered  // Device may be trusted
);
  // ---------------------------------------------------------------
  // Pin sequencing
  // ---------------------------------------------------------------
  logic req;     // Request seen at the edge
  int   armCnt;  // Setup cycles already waited
  int   wakeCnt; // Cycles since the pin fell
  initial begin
    sleepLine = 1'h0;
    recovered = 1'h1;
    armCnt = 0;
    wakeCnt = pdc_pkg::RECOVER_CYC;
  end
  // Sample at the edge, drive just after it
  always @(posedge clk) begin
    req = sleepReq;
    #1;
    if (!req) begin
      if (sleepLine) wakeCnt = 0;
      sleepLine = 1'h0;
      armCnt = 0;
    end else if (armCnt < pdc_pkg::SETUP_CYC) begin
      armCnt++; // Pins stay still before the rise
    end else begin
      sleepLine = 1'h1;
    end
    if (wakeCnt < pdc_pkg::RECOVER_CYC) wakeCnt++;
    recovered = !sleepLine && wakeCnt >= pdc_pkg::RECOVER_CYC;
  end
endmodule

// ===== tb_pdc_power_down.sv
// Self-checking bench of the sleep sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: value mismatch", $time); end end
module tb_pdc_power_down;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic       clk, rst_n, sleepEnable, sleepReq, sleepLine, recovered;
  logic [7:0] userPins, coreData, coreOe, toCore, padOut, padOe;
  logic       coreClkEn, asleep;
  logic [7:0] hOut, hOe, hIn; // Expected frozen values
  int         errors, checks, n;

  always #50 clk = ~clk;

  pdc_sleep_drv pdc_sleep_drv_inst (.clk(clk), .sleepReq(sleepReq),
    .sleepLine(sleepLine), .recovered(recovered));
  pdc_power_down pdc_power_down_inst (.clk(clk), .rst_n(rst_n),
    .sleepEnable(sleepEnable), .pinIn({userPins[7:1], sleepLine}),
    .coreData(coreData), .coreOe(coreOe), .toCore(toCore),
    .padOut(padOut), .padOe(padOe), .coreClkEn(coreClkEn),
    .asleep(asleep));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Step k edges, land just after the last
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Give up a hung wait
  task automatic hang();
    errors++;
    $display("ERROR %0t: wait timed out", $time);
    wrap_up();
  endtask
  // Bounded wait for asleep; pads must stay frozen while it is high
  task automatic waitSleep(logic v);
    n = 0;
    while (asleep !== v) begin
      if (asleep === 1'h1) begin
        `CHK(padOut, hOut)
        `CHK(padOe, hOe)
        `CHK(coreClkEn, 1'h0)
      end
      tick(1);
      n++;
      if (n > 40) hang();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {clk, rst_n, sleepReq, userPins, coreData, coreOe} = '0;
    sleepEnable = 1'h1;
    errors = 0;
    checks = 0;
    void'($urandom(32'h0f41));
    tick(4);
    rst_n = 1'h1;
    tick(1);
    `CHK(asleep, 1'h0)
    // Running: pads follow in 1 edge, pins in 5
    repeat (4) begin
      coreData = 8'($urandom);
      coreOe = 8'($urandom);
      userPins = 8'($urandom);
      tick(1);
      `CHK(padOut, coreData)
      `CHK(padOe, coreOe)
      tick(4);
      `CHK(toCore, userPins & 8'hfe)
    end
    $display("test run done");
    // Enter sleep with some pads undriven
    coreOe = 8'h5a;
    tick(6);
    {hOut, hOe, hIn} = {coreData, coreOe, userPins & 8'hfe};
    sleepReq = 1'h1;
    waitSleep(1'h1);
    `CHK(n, pdc_pkg::SETUP_CYC + 6)
    // Pin and core activity while asleep
    repeat (8) begin
      coreData = 8'($urandom);
      coreOe = 8'($urandom);
      userPins = 8'($urandom);
      tick(1);
      `CHK(toCore, hIn)
      `CHK({padOut, padOe}, {hOut, hOe})
    end
    // Release briefly, then sleep again while still waking
    sleepReq = 1'h0;
    tick(8);
    sleepReq = 1'h1;
    repeat (30) begin
      tick(1);
      `CHK(asleep, 1'h1)
      `CHK({padOut, padOe, toCore}, {hOut, hOe, hIn})
    end
    $display("test sleep done");
    // Wake and resume
    sleepReq = 1'h0;
    waitSleep(1'h0);
    `CHK(n <= pdc_pkg::RECOVER_CYC + 1, 1'h1)
    `CHK(coreClkEn, 1'h1)
    tick(1);
    `CHK(padOut, coreData)
    `CHK(padOe, coreOe)
    tick(5);
    `CHK(toCore, userPins & 8'hfe)
    n = 0;
    while (!recovered) begin
      tick(1);
      n++;
      if (n > 40) hang();
    end
    $display("test wake done");
    // Option off: pin 0 is an ordinary input
    rst_n = 1'h0;
    sleepEnable = 1'h0;
    tick(2);
    rst_n = 1'h1;
    sleepReq = 1'h1;
    repeat (24) begin
      tick(1);
      `CHK(asleep, 1'h0)
    end
    `CHK(toCore[0], 1'h1)
    $display("test option done");
    wrap_up();
  end
endmodule
